// ---- hdl/timer_type_a.sv ----
// Purpose: 16-bit PWM timer with split 8-bit mode, commands and event I/O.
// Assumes: All inputs synchronous to clk; software fields held as levels.
// Notes:   Commands and register writes are one-cycle strobes.
`timescale 1ns/1ps

module timer_type_a (
   input wire logic clk,
   input wire logic rstn,
   input wire logic enable,                        // Timer running
   input wire logic [2:0] prescaler_select,        // Clock divider select
   input wire logic [2:0] waveform_mode_select,    // Waveform mode
   input wire logic [5:0] channel_output_enable,   // Low three, then high three
   input wire logic split_enable,                  // Two 8-bit timers
   input wire logic lock_update,                   // Block natural updates
   input wire logic dir_write,                     // Strobe: load direction
   input wire logic dir_value,                     // Direction, 1 = down
   input wire logic [1:0] control_e_set_side,      // Command code strobe
   input wire timer_pwm_pkg::reg_write_t wr,       // Register write
   input wire logic event_in,                      // Routed event level
   input wire logic event_count_enable,            // Count on events
   input wire logic [1:0] event_action_field,      // Event action
   input wire logic [5:0] port_out,                // Port's own output values
   output logic [5:0] pin_value,                   // Value reaching the pins
   output logic [5:0] waveform_output,             // Waveform outputs
   output logic [15:0] counter_value,              // Counter
   output logic [15:0] period_value,               // Period in use
   output logic [3:0] buffer_valid,                // Buffer valid flags
   output logic count_down,                        // Direction state
   output timer_pwm_pkg::event_pulses_t events     // Event pulses
);

   localparam int CW = timer_pwm_pkg::CNT_W;
   localparam int BW = timer_pwm_pkg::BYTE_W;
   localparam int NC = timer_pwm_pkg::N_CH;

   // State
   logic [CW-1:0] cnt_r, cnt_nxt;                 // Counter
   logic dir_r, dir_nxt;                          // 1 = counting down
   logic [CW-1:0] per_r, per_nxt;                 // Period
   logic [CW-1:0] per_buf_r, per_buf_nxt;         // Period buffer
   logic [CW-1:0] cmp_r [NC];                     // Compare values
   logic [CW-1:0] cmp_nxt [NC];
   logic [CW-1:0] cmp_buf_r [NC];                 // Compare buffers
   logic [CW-1:0] cmp_buf_nxt [NC];
   logic [3:0] bv_r, bv_nxt;                      // Buffer valid flags
   logic [timer_pwm_pkg::PSC_W-1:0] psc_r;        // Prescaler counter
   logic ev_prev_r;                               // Event level last cycle
   logic [5:0] wo_r, wo_nxt;                      // Waveform outputs
   logic [5:0] pin_r;                             // Pin values
   timer_pwm_pkg::event_pulses_t evt_r, evt_nxt;  // Event pulses

   // Mode decode
   timer_pwm_pkg::wg_mode_t mode;
   timer_pwm_pkg::cmd_t cmd;
   timer_pwm_pkg::event_action_field_t act;
   assign mode = timer_pwm_pkg::wg_mode_t'(waveform_mode_select);
   assign cmd = timer_pwm_pkg::cmd_t'(control_e_set_side);
   assign act = timer_pwm_pkg::event_action_field_t'(event_action_field);

   wire is_single = (mode == timer_pwm_pkg::WG_SINGLE);
   wire is_dual = (mode == timer_pwm_pkg::WG_DUAL_TOP) || (mode == timer_pwm_pkg::WG_DUAL_BOTH)
                  || (mode == timer_pwm_pkg::WG_DUAL_BOTTOM);
   wire is_freq = (mode == timer_pwm_pkg::WG_FREQ);
   wire is_wave = is_single || is_dual || is_freq;

   // Commands act in the cycle they are written
   wire cmd_update = (cmd == timer_pwm_pkg::CMD_UPDATE);   // see RULE_09
   wire cmd_restart = (cmd == timer_pwm_pkg::CMD_RESTART);
   // A reset command while running is simply dropped
   wire cmd_reset = (cmd == timer_pwm_pkg::CMD_RESET) && !enable;   // see RULE_12

   // Write decode
   wire wr_cnt = wr.en && (wr.target == timer_pwm_pkg::WT_CNT);
   wire wr_per = wr.en && (wr.target == timer_pwm_pkg::WT_PER);
   // Buffers are dead in split mode, so their writes are dropped there
   wire wr_perbuf = wr.en && (wr.target == timer_pwm_pkg::WT_PERBUF)
                    && !split_enable;   // see RULE_16
   wire wr_cmp = wr.en && (wr.target == timer_pwm_pkg::WT_CMP);
   wire wr_cmpbuf = wr.en && (wr.target == timer_pwm_pkg::WT_CMPBUF) && !split_enable;

   // Prescaler: tick when the masked low bits are all ones
   wire [timer_pwm_pkg::PSC_W-1:0] psc_mask = timer_pwm_pkg::PSC_MASK[prescaler_select];
   wire psc_hit = enable && ((psc_r & psc_mask) == psc_mask);   // see RULE_03

   // Event counting is bypassed in split mode
   wire ev_gate = event_count_enable && !split_enable;   // see RULE_14
   wire ev_rise = event_in && !ev_prev_r;
   wire ev_any = event_in ^ ev_prev_r;
   // Level actions sample on prescaled ticks; a source faster than that is missed
   wire ev_tick = (act == timer_pwm_pkg::EVA_RISE) ? ev_rise :
                  (act == timer_pwm_pkg::EVA_ANY) ? ev_any :
                  (act == timer_pwm_pkg::EVA_HIGH) ? (psc_hit && event_in) :
                  psc_hit;   // see RULE_21 RULE_24
   wire count_tick = enable && (ev_gate ? ev_tick : psc_hit);

   // Effective direction: single slope is up only, event level may steer
   wire down_eff = is_single ? 1'b0 :   // see RULE_01
                   is_dual ? dir_r :
                   (ev_gate && act == timer_pwm_pkg::EVA_DIR) ? event_in : dir_r;   // see RULE_21

   wire at_top = (cnt_r == per_r);
   wire at_bot = (cnt_r == timer_pwm_pkg::CNT_ZERO);

   // Dual-slope update/overflow points depend on the sub-mode
   wire dual_point = ((mode == timer_pwm_pkg::WG_DUAL_TOP) && at_top && !dir_r)
                     || ((mode == timer_pwm_pkg::WG_DUAL_BOTTOM) && at_bot && dir_r)
                     || ((mode == timer_pwm_pkg::WG_DUAL_BOTH)
                         && ((at_top && !dir_r) || (at_bot && dir_r)));
   wire wrap_point = down_eff ? at_bot : at_top;
   wire ovf_cond = count_tick && !split_enable && (is_dual ? dual_point : wrap_point);

   // Split halves underflow when they leave zero
   wire lo_zero = (timer_pwm_pkg::lo_byte(cnt_r) == timer_pwm_pkg::BYTE_ZERO);
   wire hi_zero = (timer_pwm_pkg::hi_byte(cnt_r) == timer_pwm_pkg::BYTE_ZERO);
   wire lunf = count_tick && split_enable && lo_zero;   // see RULE_13
   wire high_underflow_event = count_tick && split_enable && hi_zero;   // see RULE_15

   // Buffer copy: natural update honours lock, the command does not
   wire do_update = !split_enable
                    && (cmd_update || (ovf_cond && !lock_update));   // see RULE_10 RULE_23

   // Split-mode next halves: reload from the period byte at bottom
   wire [BW-1:0] lo_dec = lo_zero ? timer_pwm_pkg::lo_byte(per_r)
                          : timer_pwm_pkg::lo_byte(cnt_r) - timer_pwm_pkg::BYTE_ONE;
   wire [BW-1:0] hi_dec = hi_zero ? timer_pwm_pkg::hi_byte(per_r)
                          : timer_pwm_pkg::hi_byte(cnt_r) - timer_pwm_pkg::BYTE_ONE;

   // Compare matches; split mode only the low byte raises them
   logic [NC-1:0] cmp_hit;
   genvar g;
   generate
      for (g = 0; g < NC; g++) begin : g_match
         assign cmp_hit[g] = count_tick && (split_enable ?
            (timer_pwm_pkg::lo_byte(cnt_r) == timer_pwm_pkg::lo_byte(cmp_r[g])) :
            (cnt_r == cmp_r[g]));   // see RULE_15
      end
   endgenerate

   // Counter and direction next state
   always_comb begin
      cnt_nxt = cnt_r;
      dir_nxt = dir_r;
      if (dir_write) begin
         dir_nxt = dir_value;
      end
      if (count_tick) begin
         if (split_enable) begin
            cnt_nxt = {hi_dec, lo_dec};   // see RULE_13
         end else if (is_dual) begin
            // Turn at top and bottom: 2 x period ticks per cycle
            if (!dir_r) begin
               cnt_nxt = at_top ? cnt_r - timer_pwm_pkg::CNT_ONE
                                : cnt_r + timer_pwm_pkg::CNT_ONE;   // see RULE_04 RULE_07
               dir_nxt = at_top;
            end else begin
               cnt_nxt = at_bot ? cnt_r + timer_pwm_pkg::CNT_ONE
                                : cnt_r - timer_pwm_pkg::CNT_ONE;
               dir_nxt = !at_bot;
            end
         end else if (down_eff) begin
            cnt_nxt = at_bot ? per_r : cnt_r - timer_pwm_pkg::CNT_ONE;
         end else begin
            // Up: 0..period is period plus one ticks
            cnt_nxt = at_top ? timer_pwm_pkg::CNT_ZERO
                             : cnt_r + timer_pwm_pkg::CNT_ONE;   // see RULE_01 RULE_03
         end
      end
      // A counter write beats counting
      if (wr_cnt) begin
         cnt_nxt = timer_pwm_pkg::merge_bytes(cnt_r, wr.data, wr.byte_en);
      end
      if (cmd_restart) begin
         cnt_nxt = timer_pwm_pkg::CNT_ZERO;   // see RULE_11
         dir_nxt = 1'b0;
      end
   end

   // Period, compare and buffer next state
   always_comb begin
      per_nxt = per_r;
      per_buf_nxt = per_buf_r;
      bv_nxt = bv_r;
      // Update clears the flags; a write in the same cycle keeps its flag
      if (do_update) begin
         if (bv_r[timer_pwm_pkg::BV_PER]) begin
            per_nxt = per_buf_r;
         end
         bv_nxt = '0;
      end
      if (wr_per) begin
         per_nxt = timer_pwm_pkg::merge_bytes(per_r, wr.data, wr.byte_en);
      end
      if (wr_perbuf) begin
         per_buf_nxt = timer_pwm_pkg::merge_bytes(per_buf_r, wr.data, wr.byte_en);
         bv_nxt[timer_pwm_pkg::BV_PER] = 1'b1;
      end
      for (int i = 0; i < NC; i++) begin
         cmp_nxt[i] = cmp_r[i];
         cmp_buf_nxt[i] = cmp_buf_r[i];
         if (do_update && bv_r[timer_pwm_pkg::BV_CMP0 + i]) begin
            cmp_nxt[i] = cmp_buf_r[i];   // see RULE_23
         end
         if (wr_cmp && (int'(wr.idx) == i)) begin
            cmp_nxt[i] = timer_pwm_pkg::merge_bytes(cmp_r[i], wr.data, wr.byte_en);
         end
         if (wr_cmpbuf && (int'(wr.idx) == i)) begin
            cmp_buf_nxt[i] = timer_pwm_pkg::merge_bytes(cmp_buf_r[i], wr.data, wr.byte_en);
            bv_nxt[timer_pwm_pkg::BV_CMP0 + i] = 1'b1;
         end
      end
   end

   // Waveform next state from the count being entered
   always_comb begin
      wo_nxt = wo_r;
      if (count_tick) begin
         for (int i = 0; i < NC; i++) begin
            if (split_enable) begin
               // Down-count single slope per byte
               wo_nxt[i] = timer_pwm_pkg::lo_byte(cnt_nxt) < timer_pwm_pkg::lo_byte(cmp_r[i]);
               wo_nxt[i+NC] = timer_pwm_pkg::hi_byte(cnt_nxt)
                              < timer_pwm_pkg::hi_byte(cmp_r[i]);   // see RULE_13
            end else if (is_single) begin
               // High from bottom until the match; cmp zero is static low
               wo_nxt[i] = cnt_nxt < cmp_r[i];
            end else if (is_dual) begin
               // Set below the match both ways; cmp equal top holds high
               wo_nxt[i] = (cmp_r[i] == per_r) || (cnt_nxt < cmp_r[i]);   // see RULE_04 RULE_05
            end else if (is_freq) begin
               wo_nxt[i] = wo_r[i] ^ cmp_hit[i];
            end
         end
      end
      if (cmd_restart) begin
         wo_nxt = '0;   // see RULE_11
      end
   end

   // Events fire with the same conditions as the flags
   always_comb begin
      evt_nxt.overflow_or_low_underflow_event = split_enable ? lunf : ovf_cond;   // see RULE_19 RULE_20
      evt_nxt.high_underflow_event = high_underflow_event;
      evt_nxt.cmp = cmp_hit;
   end

   // Main registers; reset command returns everything to its initial value
   always_ff @(posedge clk) begin
      if (!rstn || cmd_reset) begin   // see RULE_12
         cnt_r <= timer_pwm_pkg::CNT_RESET;
         dir_r <= 1'b0;
         per_r <= timer_pwm_pkg::PER_RESET;
         per_buf_r <= timer_pwm_pkg::PER_RESET;
         bv_r <= '0;
         wo_r <= '0;
         evt_r <= '0;
         for (int i = 0; i < NC; i++) begin
            cmp_r[i] <= timer_pwm_pkg::CMP_RESET;
            cmp_buf_r[i] <= timer_pwm_pkg::CMP_RESET;
         end
      end else begin
         cnt_r <= cnt_nxt;
         dir_r <= dir_nxt;
         per_r <= per_nxt;
         per_buf_r <= per_buf_nxt;
         bv_r <= bv_nxt;
         wo_r <= wo_nxt;
         evt_r <= evt_nxt;
         for (int i = 0; i < NC; i++) begin
            cmp_r[i] <= cmp_nxt[i];
            cmp_buf_r[i] <= cmp_buf_nxt[i];
         end
      end
   end

   // Prescaler restarts whenever the timer stops
   always_ff @(posedge clk) begin
      if (!rstn || !enable) begin
         psc_r <= '0;
      end else begin
         psc_r <= psc_r + 1'b1;
      end
   end

   // A reset command clears the waveforms, so the pins must not show the stale next value
   wire [timer_pwm_pkg::N_PIN-1:0] wo_pin = cmd_reset ? '0 : wo_nxt;   // see RULE_12

   // Event edge history and pin override
   always_ff @(posedge clk) begin
      if (!rstn) begin
         ev_prev_r <= 1'b0;
         pin_r <= '0;
      end else begin
         ev_prev_r <= event_in;
         for (int i = 0; i < timer_pwm_pkg::N_PIN; i++) begin
            // Override only with channel enabled and a waveform mode chosen
            pin_r[i] <= (channel_output_enable[i] && is_wave) ? wo_pin[i] : port_out[i];   // see RULE_08
         end
      end
   end

   assign pin_value = pin_r;
   assign waveform_output = wo_r;
   assign counter_value = cnt_r;
   assign period_value = per_r;
   assign buffer_valid = bv_r;
   assign count_down = dir_r;
   assign events = evt_r;

   // Checks
   wire quiet = !wr.en && (cmd == timer_pwm_pkg::CMD_NONE);

   sequence s_single_step;
      is_single && !split_enable && count_tick && !at_top && quiet;
   endsequence

   a_single_up_step: assert property (@(posedge clk) disable iff (!rstn)   // see RULE_01
      s_single_step |=> cnt_r == $past(cnt_r) + timer_pwm_pkg::CNT_ONE)
      else $error("single slope did not step up");

   a_split_no_events: assert property (@(posedge clk) disable iff (!rstn)   // see RULE_14
      split_enable && quiet && !psc_hit |=> $stable(cnt_r))
      else $error("split counter moved without a prescaler tick");

   a_restart_zeroes: assert property (@(posedge clk) disable iff (!rstn)   // see RULE_11
      cmd_restart && !wr.en |=> cnt_r == timer_pwm_pkg::CNT_ZERO && !dir_r && wo_r == '0)
      else $error("restart left state nonzero");

   a_update_cmd_copy: assert property (@(posedge clk) disable iff (!rstn)   // see RULE_10
      cmd_update && !split_enable && bv_r[timer_pwm_pkg::BV_PER] && !wr.en
      |=> per_r == $past(per_buf_r) && !bv_r[timer_pwm_pkg::BV_PER])
      else $error("update command did not copy period buffer");

   a_lock_holds_per: assert property (@(posedge clk) disable iff (!rstn)   // see RULE_23
      lock_update && quiet |=> $stable(per_r))
      else $error("locked period changed");

   a_reset_cmd_init: assert property (@(posedge clk) disable iff (!rstn)   // see RULE_12
      cmd_reset |=> cnt_r == timer_pwm_pkg::CNT_RESET && per_r == timer_pwm_pkg::PER_RESET)
      else $error("reset command did not restore registers");

   a_high_underflow_event_split_only: assert property (@(posedge clk) disable iff (!rstn)   // see RULE_15 RULE_19
      events.high_underflow_event |-> $past(split_enable) && $past(hi_zero))
      else $error("high underflow event outside split mode");

   a_dual_low_static: assert property (@(posedge clk) disable iff (!rstn)   // see RULE_05
      is_dual && !split_enable && cmp_r[0] == timer_pwm_pkg::CNT_ZERO && count_tick && quiet
      |=> !wo_r[0])
      else $error("dual slope cmp bottom not low");

   a_pin_override: assert property (@(posedge clk) disable iff (!rstn)   // see RULE_08
      channel_output_enable[0] && is_wave |=> pin_value[0] == waveform_output[0])
      else $error("pin not overridden by waveform");

   a_event_high_level: assert property (@(posedge clk) disable iff (!rstn)   // see RULE_21
      ev_gate && act == timer_pwm_pkg::EVA_HIGH && !event_in && quiet |=> $stable(cnt_r))
      else $error("count while high moved on low level");

endmodule : timer_type_a

// ---- hdl/timer_pwm_pkg.sv ----
// Purpose: Shared constants and types for the split-capable PWM timer.
// Assumes: One 20 MHz clock; software fields arrive as plain ports.
// Notes:   Functional notes follow; tags are used in the timer module.
// Functional notes
// RULE_01: Single-slope PWM counts upward only.
// RULE_02: Software keeps single-slope period at least 0x0002.
// RULE_03: Single-slope period lasts period plus one ticks.
// RULE_04: Dual-slope alternates direction; set/clear on matches.
// RULE_05: Dual-slope compare bottom low, top high.
// RULE_06: Software keeps dual-slope period at least 0x0003.
// RULE_07: Dual-slope period spans twice period ticks.
// RULE_08: Enabled channel waveform overrides pin value.
// RULE_09: Commands come through the command code port.
// RULE_10: Update command copies buffers despite lock.
// RULE_11: Restart zeroes counter, direction, waveform outputs.
// RULE_12: Reset command restores registers, only when disabled.
// RULE_13: Split mode gives two 8-bit down-counters.
// RULE_14: Split mode ignores event inputs.
// RULE_15: High byte gives underflow only, no compare.
// RULE_16: Split mode leaves buffers unused; byte access.
// RULE_17: Mode switch keeps register contents unchanged.
// RULE_18: Split start: split bit, period, then enable.
// RULE_19: One-cycle event pulses for overflow, underflow, compares.
// RULE_20: Event pulses match interrupt flag conditions.
// RULE_21: Event input drives counting per action field.
// RULE_22: Level event sources toggle slower than ticks.
// RULE_23: Natural update copies valid buffers unless locked.
// RULE_24: Event actions encoded 0 to 3.

package timer_pwm_pkg;

   localparam int CNT_W = 16;      // Counter and period width
   localparam int BYTE_W = 8;      // Split-mode half width
   localparam int N_CH = 3;        // Compare channels per timer
   localparam int N_PIN = 6;       // Pins: three low plus three high in split mode
   localparam int PSC_W = 10;      // Prescaler counter width (largest divider 1024)
   localparam int BV_W = 4;        // Buffer valid flags: period plus three compares
   localparam int BV_PER = 0;      // Period buffer valid bit
   localparam int BV_CMP0 = 1;     // First compare buffer valid bit

   localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
   localparam logic [CNT_W-1:0] PER_RESET = 16'hffff;
   localparam logic [CNT_W-1:0] CMP_RESET = 16'h0000;
   localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
   localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
   localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;
   localparam logic [BYTE_W-1:0] BYTE_ONE = 8'h01;

   // Prescaler masks, index is the clock select value (dividers 1..1024)
   localparam logic [PSC_W-1:0] PSC_MASK [8] = '{10'h000, 10'h001, 10'h003, 10'h007,
                                                 10'h00f, 10'h03f, 10'h0ff, 10'h3ff};

   // Waveform generation modes
   typedef enum logic [2:0] {
      WG_NORMAL = 3'h0,
      WG_FREQ = 3'h1,
      WG_SINGLE = 3'h3,
      WG_DUAL_TOP = 3'h5,
      WG_DUAL_BOTH = 3'h6,
      WG_DUAL_BOTTOM = 3'h7
   } wg_mode_t;

   // Software commands; none is the idle code
   typedef enum logic [1:0] {
      CMD_NONE = 2'h0,
      CMD_UPDATE = 2'h1,
      CMD_RESTART = 2'h2,
      CMD_RESET = 2'h3
   } cmd_t;

   // Event count actions
   typedef enum logic [1:0] {
      EVA_RISE = 2'h0,
      EVA_ANY = 2'h1,
      EVA_HIGH = 2'h2,
      EVA_DIR = 2'h3
   } event_action_field_t;

   // Register write targets
   typedef enum logic [2:0] {
      WT_CNT = 3'h0,
      WT_PER = 3'h1,
      WT_PERBUF = 3'h2,
      WT_CMP = 3'h3,
      WT_CMPBUF = 3'h4
   } wr_target_t;

   // One register write with byte enables
   typedef struct packed {
      logic en;
      wr_target_t target;
      logic [1:0] idx;
      logic [1:0] byte_en;
      logic [CNT_W-1:0] data;
   } reg_write_t;

   // Generated event pulses
   typedef struct packed {
      logic overflow_or_low_underflow_event;
      logic high_underflow_event;
      logic [N_CH-1:0] cmp;
   } event_pulses_t;

   // Merge written bytes into an old 16-bit value
   function automatic logic [CNT_W-1:0] merge_bytes(input logic [CNT_W-1:0] old,
                                                    input logic [CNT_W-1:0] data,
                                                    input logic [1:0] be);
      merge_bytes = {be[1] ? data[CNT_W-1:BYTE_W] : old[CNT_W-1:BYTE_W],
                     be[0] ? data[BYTE_W-1:0] : old[BYTE_W-1:0]};
   endfunction : merge_bytes

   // Low and high byte of a 16-bit value
   function automatic logic [BYTE_W-1:0] lo_byte(input logic [CNT_W-1:0] v);
      lo_byte = v[BYTE_W-1:0];
   endfunction : lo_byte

   function automatic logic [BYTE_W-1:0] hi_byte(input logic [CNT_W-1:0] v);
      hi_byte = v[CNT_W-1:BYTE_W];
   endfunction : hi_byte

endpackage : timer_pwm_pkg

// ---- dv/evsys_port_model.sv ----
// Purpose: Event routing and port pin model facing the timer.
// Assumes: Bench starts a burst with a one-cycle fire strobe.
// Notes:   Port output register is static so overrides stand out.
`timescale 1ns/1ps

module evsys_port_model (
   input wire logic clk,
   input wire logic fire,           // Start a burst
   input wire logic [3:0] n_pulses, // Pulses per burst
   input wire logic hold_high,      // Hold the event line high
   output logic event_in,
   output logic [5:0] port_out
);
   logic [5:0] left_r = 6'h00;      // Cycles left in the burst

   // Two cycles high, two low: slower than the timer clock
   always_ff @(posedge clk) begin
      if (fire) begin
         left_r <= {n_pulses, 2'b00};
      end else if (left_r != 6'h00) begin
         left_r <= left_r - 6'h01;
      end
   end
   assign event_in = hold_high | left_r[1];
   // Pins set as outputs with a fixed pattern
   assign port_out = 6'h2a;
endmodule : evsys_port_model

// ---- dv/tb_top.sv ----
// Purpose: Self-checking bench for the split-capable PWM timer.
// Assumes: Divider 1, except divider 2 in the split test; inputs change 1 ns after the rising edge.
// Notes:   Waveforms are judged by pulse tallies over whole periods.
`timescale 1ns/1ps

`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin errors++; \
   $display("unexpected at %0t: got %h exp %h", $time, a, b); end end

module tb_top;
   logic clk, rstn, enable, split_enable, lock_update, dir_write, dir_value;
   logic [2:0] prescaler_select, waveform_mode_select;
   logic [5:0] channel_output_enable, port_out, pin_value, waveform_output;
   logic [1:0] control_e_set_side, event_action_field;
   logic event_in, event_count_enable, count_down, fire, hold_high;
   logic [15:0] counter_value, period_value;
   logic [3:0] buffer_valid;
   timer_pwm_pkg::reg_write_t wr;
   timer_pwm_pkg::event_pulses_t ev;
   int errors = 0, n_compared = 0, cycles = 0;
   int n_ovf, n_high_underflow_event, n_cmp0, n_wo, n_pin;
   int exp_ev[3] = '{4, 8, 8};  // Rising, any edge, high level
   int exp_wo[3] = '{0, 5, 40}; // Dual slope, compare 0, 1, top

   timer_type_a uut (.clk(clk), .rstn(rstn), .enable(enable),
      .prescaler_select(prescaler_select), .waveform_mode_select(waveform_mode_select),
      .channel_output_enable(channel_output_enable), .split_enable(split_enable),
      .lock_update(lock_update), .dir_write(dir_write), .dir_value(dir_value),
      .control_e_set_side(control_e_set_side), .wr(wr), .event_in(event_in),
      .event_count_enable(event_count_enable), .event_action_field(event_action_field),
      .port_out(port_out), .pin_value(pin_value), .waveform_output(waveform_output),
      .counter_value(counter_value), .period_value(period_value),
      .buffer_valid(buffer_valid), .count_down(count_down), .events(ev));
   evsys_port_model partner (.clk(clk), .fire(fire), .n_pulses(4'h4),
      .hold_high(hold_high), .event_in(event_in), .port_out(port_out));

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // Hang guard: far beyond the few hundred cycles the tests need
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         errors++;
         final_report();
      end
   end

   task automatic step(input int n);
      repeat (n) begin
         @(posedge clk);
         #1;
      end
   endtask : step

   // Register write strobe, both bytes
   task automatic reg_wr(input timer_pwm_pkg::wr_target_t t, input logic [15:0] d);
      wr = '{1'b1, t, 2'h0, 2'h3, d};
      step(1);
      wr.en = 1'b0;
      // Let an edge pass so a following write never re-raises the strobe at once
      step(1);
   endtask : reg_wr

   task automatic cmd(input timer_pwm_pkg::cmd_t c);
      control_e_set_side = c;
      step(1);
      control_e_set_side = 2'h0;
      step(1);
   endtask : cmd

   // Tally pulses and high cycles over n cycles
   task automatic window(input int n);
      {n_ovf, n_high_underflow_event, n_cmp0, n_wo, n_pin} = '0;
      repeat (n) begin
         step(1);
         n_ovf += ev.overflow_or_low_underflow_event;
         n_high_underflow_event += ev.high_underflow_event;
         n_cmp0 += ev.cmp[0];
         n_wo += waveform_output[0];
         n_pin += pin_value[0];
      end
   endtask : window

   task automatic final_report();
      $display("compared %0d, errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : final_report

   initial begin
      {rstn, enable, split_enable, lock_update, dir_write, dir_value, fire} = 7'h00;
      {prescaler_select, waveform_mode_select, channel_output_enable} = 12'h000;
      {control_e_set_side, event_action_field, event_count_enable, hold_high} = 6'h00;
      wr = '0;
      step(2);
      rstn = 1'b1;
      // Single slope, period 2, compare 1
      reg_wr(timer_pwm_pkg::WT_PER, 16'h0002);
      reg_wr(timer_pwm_pkg::WT_CMP, 16'h0001);
      channel_output_enable = 6'h01;
      waveform_mode_select = timer_pwm_pkg::WG_SINGLE;
      enable = 1'b1;
      step(6);
      window(30);
      `CHK(n_ovf, 10)
      `CHK(n_cmp0, 10)
      `CHK(n_pin, 10)
      `CHK(pin_value[5:1], 5'h15)
      `CHK(count_down, 1'b0)
      // Dual slope, updates at bottom, period 4
      reg_wr(timer_pwm_pkg::WT_PER, 16'h0004);
      waveform_mode_select = timer_pwm_pkg::WG_DUAL_BOTTOM;
      for (int i = 0; i < 3; i++) begin
         reg_wr(timer_pwm_pkg::WT_CMP, (i == 2) ? 16'h0004 : 16'(i));
         step(10);
         window(40);
         `CHK(n_ovf, 5)
         `CHK(n_wo, exp_wo[i])
      end
      // Restart with direction down and output high
      enable = 1'b0;
      {dir_write, dir_value} = 2'h3;
      step(1);
      dir_write = 1'b0;
      cmd(timer_pwm_pkg::CMD_RESTART);
      `CHK({counter_value, count_down, waveform_output}, 23'h0)
      // Locked buffer copied by the update command only
      lock_update = 1'b1;
      reg_wr(timer_pwm_pkg::WT_PERBUF, 16'h0010);
      `CHK(buffer_valid[0], 1'b1)
      cmd(timer_pwm_pkg::CMD_UPDATE);
      `CHK({period_value, buffer_valid[0]}, 17'h00020)
      // Natural update when unlocked
      lock_update = 1'b0;
      waveform_mode_select = timer_pwm_pkg::WG_SINGLE;
      enable = 1'b1;
      reg_wr(timer_pwm_pkg::WT_PERBUF, 16'h0005);
      step(40);
      `CHK({period_value, buffer_valid[0]}, 17'h0000a)
      cmd(timer_pwm_pkg::CMD_RESET);
      `CHK(period_value, 16'h0005)
      enable = 1'b0;
      cmd(timer_pwm_pkg::CMD_RESET);
      `CHK({counter_value, period_value, buffer_valid}, 36'h0ffff0)
      // Split start: split bit, period, then enable; events ignored
      // Divider 2 leaves idle cycles, so a counted event would show
      prescaler_select = 3'h1;
      split_enable = 1'b1;
      reg_wr(timer_pwm_pkg::WT_PER, 16'h0305);
      reg_wr(timer_pwm_pkg::WT_PERBUF, 16'h0007);
      `CHK(buffer_valid, 4'h0)
      event_count_enable = 1'b1;
      fire = 1'b1;
      enable = 1'b1;
      step(1);
      fire = 1'b0;
      step(7);
      window(24);
      `CHK(n_ovf, 2)
      `CHK(n_high_underflow_event, 3)
      `CHK(n_cmp0, 2)
      // Event counting in normal mode after a clean reset
      enable = 1'b0;
      split_enable = 1'b0;
      prescaler_select = 3'h0;
      cmd(timer_pwm_pkg::CMD_RESET);
      waveform_mode_select = timer_pwm_pkg::WG_NORMAL;
      enable = 1'b1;
      for (int a = 0; a < 3; a++) begin
         event_action_field = 2'(a);
         reg_wr(timer_pwm_pkg::WT_CNT, 16'h0000);
         fire = 1'b1;
         step(1);
         fire = 1'b0;
         step(24);
         `CHK(counter_value, 16'(exp_ev[a]))
      end
      event_action_field = 2'h3;
      hold_high = 1'b1;
      reg_wr(timer_pwm_pkg::WT_CNT, 16'h0100);
      step(8);
      `CHK(counter_value < 16'h0100, 1'b1)
      final_report();
   end
endmodule : tb_top
